// file: core/ssc_pkg.sv
// Constants and types for the signal supervision comparator
package ssc_pkg;
  localparam int VAL_W = 32;
  localparam int CMP_W = 34;
  localparam int MODE_W = 4;
  localparam int ACT_W = 2;
  localparam int FTIME_W = 15;
  localparam int CODE_W = 16;
  localparam logic [FTIME_W-1:0] FTIME_MAX = 15'h7530;
  localparam logic [VAL_W-1:0] HYST_MAX = 32'h0098_9680;
  localparam logic [VAL_W-1:0] LIMIT_MAX = 32'h7FFF_FFD0;
  localparam int CLK_FREQ_MHZ = 200;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYCLES = TICK_TIME_US * CLK_FREQ_MHZ;
  localparam logic [CODE_W-1:0] CODE_NONE = 16'h0000;
  localparam logic [CODE_W-1:0] CODE_WARN = 16'hA8B5;
  localparam logic [CODE_W-1:0] CODE_FAULT = 16'h80B5;
  localparam logic [CODE_W-1:0] CODE_FAULT_RUN = 16'h80B0;
  localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;
  localparam logic [ACT_W-1:0] ACT_RESET = 2'h0;

  typedef enum logic [MODE_W-1:0] {
    SSC_OFF = 4'h0,
    SSC_LOW = 4'h1,
    SSC_HIGH = 4'h2,
    SSC_ABS_LOW = 4'h3,
    SSC_ABS_HIGH = 4'h4,
    SSC_BOTH = 4'h5,
    SSC_ABS_BOTH = 4'h6,
    SSC_LATCH = 4'h7,
    SSC_LOW_FALL = 4'h8,
    SSC_HIGH_RISE = 4'h9
  } ssc_mode_e;

  typedef enum logic [ACT_W-1:0] {
    SSC_ACT_NONE = 2'h0,
    SSC_ACT_WARN = 2'h1,
    SSC_ACT_FAULT = 2'h2,
    SSC_ACT_FAULT_RUN = 2'h3
  } ssc_act_e;
endpackage : ssc_pkg

// file: core/ssc_top.sv
// One signal supervision channel: selector, filter, comparator, action
`timescale 1ns/1ps
module ssc_top #(
  parameter int NSRC = 8,
  parameter int SEL_W = 3,
  parameter int TICK_CYC = ssc_pkg::TICK_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [NSRC*ssc_pkg::VAL_W-1:0] src_vec_i,
  input wire logic [SEL_W-1:0] src_sel_i,
  input wire logic [ssc_pkg::MODE_W-1:0] mode_i,
  input wire logic [ssc_pkg::ACT_W-1:0] action_i,
  input wire logic [ssc_pkg::FTIME_W-1:0] filt_time_i,
  input wire logic signed [ssc_pkg::VAL_W-1:0] low_lim_i,
  input wire logic signed [ssc_pkg::VAL_W-1:0] high_lim_i,
  input wire logic [ssc_pkg::VAL_W-1:0] hyst_i,
  input wire logic motor_run_i,
  input wire logic fault_clr_i,
  output logic status_o,
  output logic warn_o,
  output logic [ssc_pkg::CODE_W-1:0] warn_code_o,
  output logic fault_o,
  output logic [ssc_pkg::CODE_W-1:0] fault_code_o,
  output logic signed [ssc_pkg::VAL_W-1:0] filt_val_o
);
  import ssc_pkg::*;

  // ==========================================================
  // Settings, clamped to their legal ranges
  // ==========================================================
  logic [FTIME_W-1:0] ftime;
  logic [VAL_W-1:0] hyst;
  logic signed [VAL_W-1:0] lo_lim;
  logic signed [VAL_W-1:0] hi_lim;

  function automatic logic signed [VAL_W-1:0] clamp_lim(input logic signed [VAL_W-1:0] v);
    logic signed [VAL_W-1:0] mx;
    mx = $signed(LIMIT_MAX);
    if (v > mx) begin
      clamp_lim = mx;
    end else if (v < -mx) begin
      clamp_lim = -mx;
    end else begin
      clamp_lim = v;
    end
  endfunction : clamp_lim

  always_comb begin
    ftime = (filt_time_i > FTIME_MAX) ? FTIME_MAX : filt_time_i;
    hyst = (hyst_i > HYST_MAX) ? HYST_MAX : hyst_i;
    lo_lim = clamp_lim(low_lim_i);
    hi_lim = clamp_lim(high_lim_i);
  end

  // ==========================================================
  // Signal selection
  // ==========================================================
  // Index 0 is the constant zero source whatever src_vec_i carries
  logic signed [VAL_W-1:0] sel_val;

  always_comb begin
    sel_val = '0;
    for (int i = 1; i < NSRC; i++) begin
      if (src_sel_i == SEL_W'(i)) begin
        sel_val = src_vec_i[i*VAL_W +: VAL_W];
      end
    end
  end

  // ==========================================================
  // Millisecond tick for the filter
  // ==========================================================
  logic [$clog2(TICK_CYC+1)-1:0] tick_cnt_q;
  logic tick_q;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == ($clog2(TICK_CYC+1))'(TICK_CYC - 1)) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // ==========================================================
  // First-order filter
  // ==========================================================
  // The divide by (tau+1) is a right shift by floor(log2(tau+1)):
  // cheap, at the cost of time constants rounded down to powers of two.
  logic [4:0] fshift;
  logic signed [VAL_W:0] fdiff;
  logic signed [VAL_W:0] fstep;
  logic signed [VAL_W-1:0] filt_q;

  function automatic logic [4:0] log2_floor(input logic [FTIME_W:0] v);
    logic [4:0] r;
    r = '0;
    for (int b = 0; b <= FTIME_W; b++) begin
      if (v[b]) begin
        r = 5'(b);
      end
    end
    log2_floor = r;
  endfunction : log2_floor

  always_comb begin
    fshift = log2_floor({1'b0, ftime} + 16'h0001);
    fdiff = $signed({sel_val[VAL_W-1], sel_val}) - $signed({filt_q[VAL_W-1], filt_q});
    fstep = fdiff >>> fshift;
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      filt_q <= '0;
    end else if (ftime == '0) begin
      filt_q <= sel_val;
    end else if (tick_q) begin
      filt_q <= VAL_W'(filt_q + fstep);
    end
  end

  // ==========================================================
  // Thresholds with half the hysteresis on each side
  // ==========================================================
  logic signed [CMP_W-1:0] sig;
  logic signed [CMP_W-1:0] half;
  logic signed [CMP_W-1:0] lo_m;
  logic signed [CMP_W-1:0] lo_p;
  logic signed [CMP_W-1:0] hi_m;
  logic signed [CMP_W-1:0] hi_p;
  logic signed [CMP_W-1:0] a_sig;
  logic signed [CMP_W-1:0] a_lo_m;
  logic signed [CMP_W-1:0] a_lo_p;
  logic signed [CMP_W-1:0] a_hi_m;
  logic signed [CMP_W-1:0] a_hi_p;

  function automatic logic signed [CMP_W-1:0] mag(input logic signed [CMP_W-1:0] v);
    mag = (v < 0) ? -v : v;
  endfunction : mag

  // Two spare bits keep a clamped limit plus half the hysteresis from wrapping
  always_comb begin
    sig = CMP_W'(filt_q);
    half = $signed({2'b00, hyst >> 1});
    lo_m = CMP_W'(lo_lim) - half;
    lo_p = CMP_W'(lo_lim) + half;
    hi_m = CMP_W'(hi_lim) - half;
    hi_p = CMP_W'(hi_lim) + half;
    a_sig = mag(sig);
    a_lo_m = mag(lo_m);
    a_lo_p = mag(lo_p);
    a_hi_m = mag(hi_m);
    a_hi_p = mag(hi_p);
  end

  // ==========================================================
  // Comparator condition
  // ==========================================================
  logic cond_q;
  logic cond_d;
  logic fall_arm_q;
  logic rise_arm_q;

  always_comb begin
    cond_d = cond_q;
    case (ssc_mode_e'(mode_i))
      SSC_OFF: begin
        cond_d = 1'b0;
      end
      SSC_LOW: begin
        if (sig < lo_m) begin
          cond_d = 1'b1;
        end else if (sig > lo_p) begin
          cond_d = 1'b0;
        end
      end
      SSC_HIGH: begin
        if (sig > hi_p) begin
          cond_d = 1'b1;
        end else if (sig < hi_m) begin
          cond_d = 1'b0;
        end
      end
      // Modes 3 and 4 weigh magnitudes against one limit only
      SSC_ABS_LOW: begin
        if (a_sig < a_lo_m) begin
          cond_d = 1'b1;
        end else if (a_sig > a_lo_p) begin
          cond_d = 1'b0;
        end
      end
      SSC_ABS_HIGH: begin
        if (a_sig > a_hi_p) begin
          cond_d = 1'b1;
        end else if (a_sig < a_hi_m) begin
          cond_d = 1'b0;
        end
      end
      SSC_BOTH: begin
        if (sig > hi_p || sig < lo_m) begin
          cond_d = 1'b1;
        end else if (sig < hi_m && sig > lo_p) begin
          cond_d = 1'b0;
        end
      end
      SSC_ABS_BOTH: begin
        if (a_sig > a_hi_p || a_sig < a_lo_m) begin
          cond_d = 1'b1;
        end else if (a_sig < a_hi_m && a_sig > a_lo_p) begin
          cond_d = 1'b0;
        end
      end
      SSC_LATCH: begin
        if (sig > hi_p) begin
          cond_d = 1'b1;
        end else if (sig < lo_m) begin
          cond_d = 1'b0;
        end else begin
          cond_d = cond_q;
        end
      end
      SSC_LOW_FALL: begin
        if (sig > lo_p) begin
          cond_d = 1'b0;
        end else if (fall_arm_q && sig < lo_m) begin
          cond_d = 1'b1;
        end
      end
      SSC_HIGH_RISE: begin
        if (sig < hi_m) begin
          cond_d = 1'b0;
        end else if (rise_arm_q && sig > hi_p) begin
          cond_d = 1'b1;
        end
      end
      default: begin
        cond_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cond_q <= 1'b0;
    end else begin
      cond_q <= cond_d;
    end
  end

  // Arm flags remember that the signal was last seen on the far side of
  // the band, so a slow pass through the band still counts as a crossing.
  // They track in every mode, so switching into an edge mode needs no warm-up.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      fall_arm_q <= 1'b0;
    end else if (sig > lo_p) begin
      fall_arm_q <= 1'b1;
    end else if (sig < lo_m) begin
      fall_arm_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rise_arm_q <= 1'b0;
    end else if (sig < hi_m) begin
      rise_arm_q <= 1'b1;
    end else if (sig > hi_p) begin
      rise_arm_q <= 1'b0;
    end
  end

  // ==========================================================
  // Warning and fault actions
  // ==========================================================
  logic rise;
  logic trip;
  logic [CODE_W-1:0] trip_code;

  always_comb begin
    rise = cond_d & ~cond_q;
    trip = 1'b0;
    trip_code = CODE_NONE;
    case (ssc_act_e'(action_i))
      SSC_ACT_FAULT: begin
        trip = rise;
        trip_code = CODE_FAULT;
      end
      SSC_ACT_FAULT_RUN: begin
        trip = rise & motor_run_i;
        trip_code = CODE_FAULT_RUN;
      end
      default: begin
        trip = 1'b0;
      end
    endcase
  end

  // Status follows the comparison alone
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      status_o <= 1'b0;
      filt_val_o <= '0;
    end else begin
      status_o <= cond_d;
      filt_val_o <= filt_q;
    end
  end

  // Warning is a plain level and needs no clear, unlike the latched fault
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      warn_o <= 1'b0;
      warn_code_o <= CODE_NONE;
    end else if (cond_d && action_i == SSC_ACT_WARN) begin
      warn_o <= 1'b1;
      warn_code_o <= CODE_WARN;
    end else begin
      warn_o <= 1'b0;
      warn_code_o <= CODE_NONE;
    end
  end

  // A new trip in the clearing cycle wins over the clear
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      fault_o <= 1'b0;
      fault_code_o <= CODE_NONE;
    end else if (trip) begin
      fault_o <= 1'b1;
      fault_code_o <= trip_code;
    end else if (fault_clr_i) begin
      fault_o <= 1'b0;
      fault_code_o <= CODE_NONE;
    end
  end
endmodule : ssc_top

// file: testbench/ssc_monitor.sv
// Assertion checker for one supervision channel
`timescale 1ns/1ps
module ssc_monitor (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [ssc_pkg::MODE_W-1:0] mode_i,
  input wire logic [ssc_pkg::ACT_W-1:0] action_i,
  input wire logic signed [ssc_pkg::VAL_W-1:0] low_lim_i,
  input wire logic signed [ssc_pkg::VAL_W-1:0] high_lim_i,
  input wire logic [ssc_pkg::VAL_W-1:0] hyst_i,
  input wire logic motor_run_i,
  input wire logic status_o,
  input wire logic warn_o,
  input wire logic [ssc_pkg::CODE_W-1:0] warn_code_o,
  input wire logic fault_o,
  input wire logic [ssc_pkg::CODE_W-1:0] fault_code_o,
  input wire logic signed [ssc_pkg::VAL_W-1:0] filt_val_o
);
  import ssc_pkg::*;
  // ==========================================
  // Settings as seen by the comparison
  logic rst_q;
  logic run_q;
  logic [3:0] mode_q;
  logic [1:0] act_q;
  logic signed [33:0] hh;
  logic signed [33:0] hu_q, hd_q, lu_q, ld_q;
  assign hh = $signed({3'h0, hyst_i[31:1]});
  // Status lags settings by one edge, so thresholds are kept one edge too
  always_ff @(posedge sys_clk_i) begin
    rst_q <= sys_rst_i;
    run_q <= motor_run_i;
    mode_q <= mode_i;
    act_q <= action_i;
    hu_q <= high_lim_i + hh;
    hd_q <= high_lim_i - hh;
    lu_q <= low_lim_i + hh;
    ld_q <= low_lim_i - hh;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i || rst_q);
  sequence cond_rise;
    !status_o ##1 status_o;
  endsequence
  // ==========================================
  // Properties
  off_mode_a: assert property (mode_q == 4'h0 |-> !status_o)
    else $error("status set while off");
  low_mode_a: assert property (mode_q == 4'h1 && (filt_val_o < ld_q || filt_val_o > lu_q)
    |-> status_o == (filt_val_o < ld_q)) else $error("low mode status wrong");
  high_mode_a: assert property (mode_q == 4'h2 && (filt_val_o > hu_q || filt_val_o < hd_q)
    |-> status_o == (filt_val_o > hu_q)) else $error("high mode status wrong");
  both_set_a: assert property (mode_q == 4'h5 && (filt_val_o > hu_q || filt_val_o < ld_q)
    |-> status_o) else $error("window mode not set");
  both_clear_a: assert property (mode_q == 4'h5 && filt_val_o > lu_q && filt_val_o < hd_q
    |-> !status_o) else $error("window mode not cleared");
  latch_mode_a: assert property (mode_q == 4'h7
    |-> status_o == (filt_val_o > hu_q || (filt_val_o >= ld_q && $past(status_o))))
    else $error("latching mode status wrong");
  fall_edge_a: assert property (mode_q == 4'h8 && $rose(status_o) |-> filt_val_o < ld_q)
    else $error("falling mode set without crossing");
  rise_edge_a: assert property (mode_q == 4'h9 && $rose(status_o) |-> filt_val_o > hu_q)
    else $error("rising mode set without crossing");
  warn_level_a: assert property (warn_o == (status_o && act_q == 2'h1))
    else $error("warning level wrong");
  warn_code_a: assert property (warn_code_o == (warn_o ? CODE_WARN : CODE_NONE))
    else $error("warning code wrong");
  fault_trip_a: assert property (cond_rise ##0 act_q == 2'h2
    |-> fault_o && fault_code_o == CODE_FAULT) else $error("fault trip missing");
  run_trip_a: assert property (cond_rise ##0 (act_q == 2'h3 && run_q)
    |-> fault_o && fault_code_o == CODE_FAULT_RUN) else $error("running trip missing");
  fault_cause_a: assert property (!fault_o ##1 fault_o |-> $rose(status_o) && act_q[1])
    else $error("fault without cause");
endmodule : ssc_monitor

bind ssc_top ssc_monitor i_mon (.sys_clk_i, .sys_rst_i, .mode_i, .action_i, .low_lim_i, .high_lim_i,
  .hyst_i, .motor_run_i, .status_o, .warn_o, .warn_code_o, .fault_o, .fault_code_o, .filt_val_o);

// file: testbench/ssc_src_model.sv
// Internal signal source model feeding the channel selector
`timescale 1ns/1ps
module ssc_src_model #(
  parameter int NSRC = 8
) (
  input wire logic sys_clk_i,
  input wire logic signed [ssc_pkg::VAL_W-1:0] val_i,
  output logic [NSRC*ssc_pkg::VAL_W-1:0] src_vec_o
);
  import ssc_pkg::*;
  logic [31:0] tog_q = 32'h0;
  // Slot 0 keeps moving so a selector leak shows; odd slots carry the value, even ones its negation
  always_ff @(posedge sys_clk_i) begin
    tog_q <= tog_q + 32'h1357_9BDF;
    for (int i = 0; i < NSRC; i++) begin
      src_vec_o[i*VAL_W+:VAL_W] <= (i == 0) ? tog_q : (i[0] ? val_i : -val_i);
    end
  end
endmodule : ssc_src_model

// file: testbench/test_signal_supervision_comparator.sv
// Self-checking bench for one supervision channel
`timescale 1ns/1ps
module test_signal_supervision_comparator;
  import ssc_pkg::*;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [8*VAL_W-1:0] src_vec_i;
  logic [2:0] src_sel_i = 3'h1;
  logic [MODE_W-1:0] mode_i = 4'h0;
  logic [ACT_W-1:0] action_i = 2'h0;
  logic [FTIME_W-1:0] filt_time_i = 15'h0;
  logic signed [VAL_W-1:0] low_lim_i = 32'h0;
  logic signed [VAL_W-1:0] high_lim_i = 32'h0;
  logic [VAL_W-1:0] hyst_i = 32'h0;
  logic motor_run_i = 1'b0;
  logic fault_clr_i = 1'b0;
  logic signed [VAL_W-1:0] val = 32'h0;
  logic status_o, warn_o, fault_o;
  logic [CODE_W-1:0] warn_code_o, fault_code_o;
  logic signed [VAL_W-1:0] filt_val_o;
  int failures = 0;
  int check_count = 0;
  ssc_src_model i_src (.sys_clk_i(sys_clk_i), .val_i(val), .src_vec_o(src_vec_i));
  ssc_top #(.TICK_CYC(4)) i_dut (.sys_clk_i, .sys_rst_i, .src_vec_i, .src_sel_i, .mode_i, .action_i,
    .filt_time_i, .low_lim_i, .high_lim_i, .hyst_i, .motor_run_i, .fault_clr_i, .status_o, .warn_o,
    .warn_code_o, .fault_o, .fault_code_o, .filt_val_o);
  initial forever #2.5 sys_clk_i = ~sys_clk_i;
  // ==========================================
  // Shared tasks
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : cyc
  task automatic cfg(logic [3:0] m, logic [1:0] a, int lo, int hi);
    mode_i <= m;
    action_i <= a;
    low_lim_i <= lo;
    high_lim_i <= hi;
    hyst_i <= 32'h64;
  endtask : cfg
  // Source model adds one edge to the two-edge path, so three edges settle while filt_time_i is zero
  task automatic st(int v, logic s);
    val <= v;
    cyc(4);
    #1;
    chk("status", status_o, s);
    @(posedge sys_clk_i);
  endtask : st
  task automatic clr;
    fault_clr_i <= 1'b1;
    cyc(1);
    fault_clr_i <= 1'b0;
    cyc(2);
  endtask : clr
  task automatic finish_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  // ==========================================
  // Scenarios
  task automatic t_base;
    #1;
    chk("fault", fault_code_o, CODE_NONE);
    cyc(1);
    src_sel_i <= 3'h0;
    st(32'h3E8, 1'b0);
    #1;
    chk("filt", filt_val_o, 32'h0);
    cyc(1);
    src_sel_i <= 3'h1;
    cfg(4'h2, 2'h2, 0, 32'h3E8);
    cyc(1);
    hyst_i <= 32'hC8;
    st(32'h4B0, 1'b1);
    #1;
    chk("fcode", fault_code_o, CODE_FAULT);
    cyc(1);
    st(32'h41A, 1'b1);
    st(32'h352, 1'b0);
    #1;
    chk("fault", fault_o, 1'b1);
    cyc(1);
    clr();
    #1;
    chk("fault", fault_o, 1'b0);
    cyc(1);
  endtask : t_base
  task automatic t_low;
    cfg(4'h1, 2'h1, -32'sh1F4, 0);
    st(-32'sh258, 1'b1);
    #1;
    chk("wcode", warn_code_o, CODE_WARN);
    cyc(1);
    st(-32'sh1E0, 1'b1);
    st(-32'sh190, 1'b0);
    #1;
    chk("wcode", warn_code_o, CODE_NONE);
    cyc(1);
  endtask : t_low
  task automatic t_window;
    cfg(4'h5, 2'h0, 0, 32'h3E8);
    st(32'h44C, 1'b1);
    st(32'h1F4, 1'b0);
    st(-32'sh64, 1'b1);
    st(32'h1F4, 1'b0);
    cfg(4'h6, 2'h0, 32'hC8, 32'h3E8);
    src_sel_i <= 3'h2;
    st(32'h44C, 1'b1);
    st(32'h1F4, 1'b0);
    st(32'h64, 1'b1);
    src_sel_i <= 3'h1;
    cfg(4'h3, 2'h0, 32'h1F4, 0);
    st(32'h258, 1'b0);
    st(-32'sh190, 1'b1);
    st(-32'sh1F4, 1'b1);
    st(32'h258, 1'b0);
    cfg(4'h4, 2'h0, 0, 32'h3E8);
    st(-32'sh44C, 1'b1);
    st(-32'sh3E8, 1'b1);
    st(32'h384, 1'b0);
  endtask : t_window
  task automatic t_latch;
    cfg(4'h7, 2'h0, 0, 32'h3E8);
    st(32'h44C, 1'b1);
    st(32'h1F4, 1'b1);
    st(-32'sh64, 1'b0);
    st(32'h1F4, 1'b0);
  endtask : t_latch
  task automatic t_edges;
    cfg(4'h0, 2'h0, 0, 32'h3E8);
    st(-32'sh64, 1'b0);
    st(32'h0, 1'b0);
    mode_i <= 4'h8;
    st(-32'sh64, 1'b0);
    st(32'h1F4, 1'b0);
    st(-32'sh64, 1'b1);
    st(32'h14, 1'b1);
    st(32'h64, 1'b0);
    mode_i <= 4'h0;
    st(32'h44C, 1'b0);
    mode_i <= 4'h9;
    st(32'h44C, 1'b0);
    st(32'h1F4, 1'b0);
    st(32'h44C, 1'b1);
    st(32'h3E8, 1'b1);
    st(32'h384, 1'b0);
  endtask : t_edges
  task automatic t_action;
    cfg(4'h2, 2'h3, 0, 32'h3E8);
    st(32'h4B0, 1'b1);
    #1;
    chk("fault", fault_o, 1'b0);
    cyc(1);
    st(32'h1F4, 1'b0);
    motor_run_i <= 1'b1;
    st(32'h4B0, 1'b1);
    #1;
    chk("fcode", fault_code_o, CODE_FAULT_RUN);
    cyc(1);
    clr();
    action_i <= 2'h0;
    st(32'h1F4, 1'b0);
    st(32'h4B0, 1'b1);
    #1;
    chk("act", {warn_o, fault_o}, 2'h0);
    cyc(1);
    st(32'h1F4, 1'b0);
    filt_time_i <= 15'h3E8;
    st(32'h7D0, 1'b0);
    filt_time_i <= 15'h0;
    st(32'h7D0, 1'b1);
  endtask : t_action
  initial begin
    cyc(2);
    sys_rst_i <= 1'b0;
    t_base();
    t_low();
    t_window();
    t_latch();
    t_edges();
    t_action();
    finish_test();
  end
  initial begin
    #20us;
    failures++;
    finish_test();
  end
endmodule : test_signal_supervision_comparator
